// file: src/crs_pkg.sv
// Constants and types for the charge-array readout sequencer
//
// Overview of operation
// - Readout begins with one simultaneous vertical row transfer toward the serial register.
// - Each row's pixels are clocked one by one to the output node and digitized.
// - No next row transfer until every pixel of the current row is digitized.
// - Pixels leave row by row, columns in order within each row.
// - Full resolution: each pixel is converted as its own sample, no combining.
// - Full-frame frame period is readout plus exposure plus shutter compensation.
// - Readout time is pixels times (shift plus convert) plus lines times line transfer.
// - A 1024x1024 full-frame readout at 1 MHz takes about 1.1 s.
// - Region of interest: only region pixels digitized, others shifted out and discarded.
// - Frame transfer: exposed half integrates continuously, masked half only stores.
// - After frame-transfer exposure, all rows dump quickly into the masked half.
// - Frame transfer: masked half reads out while the exposed half integrates.
// - A 512x512 frame-transfer readout at 1 MHz takes about 0.26 s.
// - Interline overlapped: a new exposure starts while the previous readout runs.
// - Exposure shorter than readout selects non-overlapped operation automatically; the code compares with the previous readout (zero after reset).
// - Overlapped: cells move to storage columns, row shifting and next exposure start at once.
// - Storage rows move one at a time to the readout register until the array is empty.
// - Overlapped: imaging cells integrate through and after readout until exposure expires.
// - Active-low readout indicator is low in readout, high in exposure and compensation.
// - Non-overlapped: imaging cells are off and do not integrate during readout.
// - After non-overlapped readout, free-run re-enables cells; triggered mode waits for sync; the code waits only for interline with early_open_option clear.
package crs_pkg;
	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned PIX_HZ        = 1_000_000;
	localparam int unsigned PIX_CYC       = CLK_HZ / PIX_HZ;
	localparam int unsigned SHIFT_CYC     = PIX_CYC / 2;
	localparam int unsigned LINE_CYC      = 50;
	localparam int unsigned DUMP_CYC      = 1;
	localparam int unsigned DIM_W         = 11;
	localparam int unsigned CNT_W         = 32;
	localparam int unsigned PIX_W         = 16;
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_EXP      = 8'h04;
	localparam logic [7:0]  ADDR_COMP     = 8'h08;
	localparam logic [7:0]  ADDR_DIM      = 8'h0C;
	localparam logic [7:0]  ADDR_ROI_C    = 8'h10;
	localparam logic [7:0]  ADDR_ROI_R    = 8'h14;
	localparam logic [7:0]  ADDR_STAT     = 8'h18;
	localparam logic [7:0]  ADDR_RDCYC    = 8'h1C;
	localparam int unsigned CTRL_RUN      = 0;
	localparam int unsigned CTRL_ARCH_LO  = 1;
	localparam int unsigned CTRL_EXT      = 3;
	localparam int unsigned CTRL_EARLY    = 4;
	localparam int unsigned DIM_ROWS_LO   = 16;
	localparam logic [31:0] EXP_RST       = 32'h0000_C350;
	localparam logic [31:0] COMP_RST      = 32'h0000_0000;
	localparam logic [DIM_W-1:0] DIM_RST  = 11'h400;

	typedef enum logic [1:0] {
		ARCH_FULL,
		ARCH_FT,
		ARCH_IL
	} crs_arch_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_EXPOSE,
		ST_COMP,
		ST_DUMP,
		ST_LINE,
		ST_PIXEL,
		ST_WAIT_SYNC
	} crs_state_t;
endpackage : crs_pkg

// file: src/crs_sequencer.sv
// Readout sequencer for full-frame, frame-transfer and interline arrays
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/100ps
module crs_sequencer (
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [7:0]                     paddr,
	input  wire logic [31:0]                    pwdata,
	output logic      [31:0]                    prdata,
	output logic                                pready,
	output logic                                pslverr,
	input  wire logic                           ext_sync,
	input  wire logic [crs_pkg::PIX_W-1:0]      adc_data,
	output logic                                vert_shift,
	output logic                                serial_shift,
	output logic                                adc_convert,
	output logic                                store_dump,
	output logic                                image_enable,
	output logic                                readout_indicator_n,
	output logic                                pix_valid,
	output logic      [crs_pkg::PIX_W-1:0]      pix_data,
	output logic                                frame_done
);
	typedef struct packed {
		logic                           run;
		logic [1:0]                     arch;
		logic                           ext_mode;
		logic                           early_open_option;
		logic [31:0]                    exp_tc;
		logic [31:0]                    comp_tc;
		logic [crs_pkg::DIM_W-1:0]      cols;
		logic [crs_pkg::DIM_W-1:0]      rows;
		logic [crs_pkg::DIM_W-1:0]      roi_c0;
		logic [crs_pkg::DIM_W-1:0]      roi_c1;
		logic [crs_pkg::DIM_W-1:0]      roi_r0;
		logic [crs_pkg::DIM_W-1:0]      roi_r1;
		crs_pkg::crs_state_t            st;
		logic [31:0]                    cyc;
		logic [31:0]                    exp_cnt;
		logic                           exp_on;
		logic                           ovl;
		logic [crs_pkg::DIM_W-1:0]      row;
		logic [crs_pkg::DIM_W-1:0]      col;
		logic [31:0]                    rd_cnt;
		logic [31:0]                    rd_last;
		logic                           sync_m;
		logic                           sync_s;
		logic                           sync_p;
		logic [31:0]                    prdata;
		logic                           pready;
		logic                           pslverr;
		logic                           vert_shift;
		logic                           serial_shift;
		logic                           adc_convert;
		logic                           store_dump;
		logic                           image_enable;
		logic                           ind_n;
		logic                           pix_valid;
		logic [crs_pkg::PIX_W-1:0]      pix_data;
		logic                           frame_done;
	} crs_state_s_t;

	crs_state_s_t s_q;
	crs_state_s_t s_d;

	logic                       acc;
	logic                       wr_en;
	logic                       in_roi;
	logic                       sync_rise;
	logic                       last_col;
	logic                       last_row;
	logic                       exp_done;

	always_comb begin
		s_d = s_q;
		acc = psel && penable && !s_q.pready;
		wr_en = psel && penable && pwrite && s_q.pready;
		in_roi = (s_q.col >= s_q.roi_c0) && (s_q.col <= s_q.roi_c1) &&
			(s_q.row >= s_q.roi_r0) && (s_q.row <= s_q.roi_r1);
		last_col = (s_q.col == s_q.cols - 11'h001);
		last_row = (s_q.row == s_q.rows - 11'h001);
		sync_rise = s_q.sync_s && !s_q.sync_p;
		exp_done = s_q.exp_on && (s_q.exp_cnt >= s_q.exp_tc);

		// Two-stage synchroniser for the external trigger
		s_d.sync_m = ext_sync;
		s_d.sync_s = s_q.sync_m;
		s_d.sync_p = s_q.sync_s;

		// APB slave, one wait state; a write lands on the edge that completes the transfer
		s_d.pready = acc;
		s_d.pslverr = 1'b0;
		if (wr_en) begin
			if (paddr == crs_pkg::ADDR_CTRL) begin
				s_d.run = pwdata[crs_pkg::CTRL_RUN];
				s_d.arch = pwdata[crs_pkg::CTRL_ARCH_LO +: 2];
				s_d.ext_mode = pwdata[crs_pkg::CTRL_EXT];
				s_d.early_open_option = pwdata[crs_pkg::CTRL_EARLY];
			end else if (paddr == crs_pkg::ADDR_EXP) begin
				s_d.exp_tc = pwdata;
			end else if (paddr == crs_pkg::ADDR_COMP) begin
				s_d.comp_tc = pwdata;
			end else if (paddr == crs_pkg::ADDR_DIM) begin
				s_d.cols = pwdata[crs_pkg::DIM_W-1:0];
				s_d.rows = pwdata[crs_pkg::DIM_ROWS_LO +: crs_pkg::DIM_W];
			end else if (paddr == crs_pkg::ADDR_ROI_C) begin
				s_d.roi_c0 = pwdata[crs_pkg::DIM_W-1:0];
				s_d.roi_c1 = pwdata[crs_pkg::DIM_ROWS_LO +: crs_pkg::DIM_W];
			end else if (paddr == crs_pkg::ADDR_ROI_R) begin
				s_d.roi_r0 = pwdata[crs_pkg::DIM_W-1:0];
				s_d.roi_r1 = pwdata[crs_pkg::DIM_ROWS_LO +: crs_pkg::DIM_W];
			end
		end
		// Decode in the access cycle; read-only registers take writes without error
		s_d.prdata = 32'h0000_0000;
		if (acc) begin
			if (paddr == crs_pkg::ADDR_CTRL) begin
				s_d.prdata = {27'h0, s_q.early_open_option, s_q.ext_mode, s_q.arch, s_q.run};
			end else if (paddr == crs_pkg::ADDR_EXP) begin
				s_d.prdata = s_q.exp_tc;
			end else if (paddr == crs_pkg::ADDR_COMP) begin
				s_d.prdata = s_q.comp_tc;
			end else if (paddr == crs_pkg::ADDR_DIM) begin
				s_d.prdata = {5'h0, s_q.rows, 5'h0, s_q.cols};
			end else if (paddr == crs_pkg::ADDR_ROI_C) begin
				s_d.prdata = {5'h0, s_q.roi_c1, 5'h0, s_q.roi_c0};
			end else if (paddr == crs_pkg::ADDR_ROI_R) begin
				s_d.prdata = {5'h0, s_q.roi_r1, 5'h0, s_q.roi_r0};
			end else if (paddr == crs_pkg::ADDR_STAT) begin
				s_d.prdata = {s_q.row, s_q.col, 5'h0, s_q.ovl, s_q.exp_on, s_q.st};
			end else if (paddr == crs_pkg::ADDR_RDCYC) begin
				s_d.prdata = s_q.rd_last;
			end else begin
				s_d.pslverr = 1'b1;
			end
			if (pwrite) begin
				s_d.prdata = 32'h0000_0000;
			end
		end

		// Exposure timer runs independently so it can overlap readout
		if (s_q.exp_on) begin
			s_d.exp_cnt = s_q.exp_cnt + 32'h1;
		end

		s_d.vert_shift = 1'b0;
		s_d.serial_shift = 1'b0;
		s_d.adc_convert = 1'b0;
		s_d.store_dump = 1'b0;
		s_d.pix_valid = 1'b0;
		s_d.frame_done = 1'b0;
		s_d.cyc = s_q.cyc + 32'h1;
		if (s_q.st == crs_pkg::ST_LINE || s_q.st == crs_pkg::ST_PIXEL) begin
			s_d.rd_cnt = s_q.rd_cnt + 32'h1;
		end

		case (s_q.st)
			crs_pkg::ST_IDLE: begin
				s_d.ind_n = 1'b1;
				if (s_q.run) begin
					s_d.st = crs_pkg::ST_EXPOSE;
					s_d.exp_on = 1'b1;
					s_d.exp_cnt = 32'h0;
					s_d.image_enable = 1'b1;
				end
			end
			crs_pkg::ST_EXPOSE: begin
				s_d.ind_n = 1'b1;
				if (exp_done) begin
					s_d.exp_on = 1'b0;
					s_d.cyc = 32'h0;
					s_d.st = (s_q.arch == 2'(crs_pkg::ARCH_FULL)) ? crs_pkg::ST_COMP : crs_pkg::ST_DUMP;
					if (s_q.arch == 2'(crs_pkg::ARCH_FULL)) begin
						s_d.image_enable = 1'b0;
					end
				end
			end
			crs_pkg::ST_COMP: begin
				s_d.ind_n = 1'b1;
				if (s_q.cyc >= s_q.comp_tc) begin
					s_d.st = crs_pkg::ST_LINE;
					s_d.cyc = 32'h0;
					s_d.row = '0;
					s_d.rd_cnt = 32'h0;
				end
			end
			crs_pkg::ST_DUMP: begin
				// Frame transfer dumps all rows; interline moves cells to storage columns
				s_d.store_dump = 1'b1;
				s_d.ind_n = 1'b0;
				if (s_q.cyc >= 32'(crs_pkg::DUMP_CYC) - 32'h1) begin
					s_d.st = crs_pkg::ST_LINE;
					s_d.cyc = 32'h0;
					s_d.row = '0;
					s_d.rd_cnt = 32'h0;
					// Frame transfer always overlaps; interline overlaps when exposure is at least as long as the previous readout
					s_d.ovl = (s_q.arch == 2'(crs_pkg::ARCH_FT)) ||
						(s_q.exp_tc >= s_q.rd_last);
					if (s_d.ovl) begin
						s_d.exp_on = 1'b1;
						s_d.exp_cnt = 32'h0;
						s_d.image_enable = 1'b1;
					end else begin
						s_d.image_enable = 1'b0;
					end
				end
			end
			crs_pkg::ST_LINE: begin
				s_d.ind_n = 1'b0;
				s_d.vert_shift = (s_q.cyc == 32'h0);
				if (s_q.cyc >= 32'(crs_pkg::LINE_CYC) - 32'h1) begin
					s_d.st = crs_pkg::ST_PIXEL;
					s_d.cyc = 32'h0;
					s_d.col = '0;
				end
			end
			crs_pkg::ST_PIXEL: begin
				s_d.ind_n = 1'b0;
				s_d.serial_shift = (s_q.cyc == 32'h0);
				// Pixels outside the region are still shifted but never converted
				s_d.adc_convert = in_roi && (s_q.cyc == 32'(crs_pkg::SHIFT_CYC));
				if (in_roi && s_q.cyc == 32'(crs_pkg::PIX_CYC) - 32'h1) begin
					s_d.pix_valid = 1'b1;
					s_d.pix_data = adc_data;
				end
				if (s_q.cyc >= 32'(crs_pkg::PIX_CYC) - 32'h1) begin
					s_d.cyc = 32'h0;
					s_d.col = s_q.col + 11'h001;
					if (last_col) begin
						s_d.row = s_q.row + 11'h001;
						if (last_row) begin
							s_d.frame_done = 1'b1;
							s_d.rd_last = s_q.rd_cnt + 32'h1;
							s_d.ind_n = 1'b1;
							if (s_q.ovl) begin
								s_d.st = crs_pkg::ST_EXPOSE;
							end else if (s_q.arch != 2'(crs_pkg::ARCH_IL) || !s_q.ext_mode ||
								s_q.early_open_option) begin
								s_d.st = s_q.run ? crs_pkg::ST_EXPOSE : crs_pkg::ST_IDLE;
								s_d.exp_on = s_q.run;
								s_d.exp_cnt = 32'h0;
								s_d.image_enable = s_q.run;
							end else begin
								s_d.st = crs_pkg::ST_WAIT_SYNC;
							end
						end else begin
							s_d.st = crs_pkg::ST_LINE;
						end
					end
				end
			end
			crs_pkg::ST_WAIT_SYNC: begin
				s_d.ind_n = 1'b1;
				if (!s_q.run) begin
					s_d.st = crs_pkg::ST_IDLE;
				end else if (sync_rise) begin
					s_d.st = crs_pkg::ST_EXPOSE;
					s_d.exp_on = 1'b1;
					s_d.exp_cnt = 32'h0;
					s_d.image_enable = 1'b1;
				end
			end
			default: begin
				s_d.st = crs_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.exp_tc <= crs_pkg::EXP_RST;
			s_q.comp_tc <= crs_pkg::COMP_RST;
			s_q.cols <= crs_pkg::DIM_RST;
			s_q.rows <= crs_pkg::DIM_RST;
			s_q.roi_c1 <= crs_pkg::DIM_RST - 11'h001;
			s_q.roi_r1 <= crs_pkg::DIM_RST - 11'h001;
			s_q.st <= crs_pkg::ST_IDLE;
			s_q.ind_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign vert_shift = s_q.vert_shift;
	assign serial_shift = s_q.serial_shift;
	assign adc_convert = s_q.adc_convert;
	assign store_dump = s_q.store_dump;
	assign image_enable = s_q.image_enable;
	assign readout_indicator_n = s_q.ind_n;
	assign pix_valid = s_q.pix_valid;
	assign pix_data = s_q.pix_data;
	assign frame_done = s_q.frame_done;
endmodule : crs_sequencer

// file: test/crs_sequencer_sva.sv
// Port assertions for the readout sequencer
`timescale 1ns/100ps
module crs_sequencer_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic vert_shift,
	input wire logic serial_shift,
	input wire logic adc_convert,
	input wire logic store_dump,
	input wire logic readout_indicator_n,
	input wire logic pix_valid,
	input wire logic frame_done
);
	logic [7:0] since_q;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Cycles since the last serial shift, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since_q <= 8'hFF;
		end else if (serial_shift) begin
			since_q <= 8'h00;
		end else if (since_q != 8'hFF) begin
			since_q <= since_q + 8'h01;
		end
	end
	a_answer_one_wait: assert property (psel && penable && !pready |=> pready) else $error("late ready");
	a_ready_one_cycle: assert property (pready |=> !pready) else $error("long ready");
	a_error_with_ready: assert property (pslverr |-> pready) else $error("stray error");
	a_row_then_pixel: assert property (vert_shift |-> ##[1:60] serial_shift) else $error("no pixel shift");
	a_row_after_pixel: assert property (vert_shift |-> since_q >= 8'h28) else $error("row too early");
	a_convert_mid_pixel: assert property (adc_convert |-> since_q >= 8'h14 && since_q <= 8'h1E)
		else $error("convert misplaced");
	a_convert_gives_pixel: assert property (adc_convert |-> ##[1:40] pix_valid) else $error("no pixel");
	a_scan_low_readout: assert property (vert_shift || serial_shift || adc_convert || store_dump
		|-> !readout_indicator_n) else $error("indicator high in readout");
	a_done_one_cycle: assert property (frame_done |=> !frame_done) else $error("long done");
endmodule : crs_sequencer_sva
bind crs_sequencer crs_sequencer_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .vert_shift(vert_shift), .serial_shift(serial_shift),
	.adc_convert(adc_convert), .store_dump(store_dump), .readout_indicator_n(readout_indicator_n),
	.pix_valid(pix_valid), .frame_done(frame_done));

// file: test/crs_sensor_model.sv
// Behavioural charge array with output digitizer
`timescale 1ns/100ps
module crs_sensor_model (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      vert_shift,
	input  wire logic                      serial_shift,
	input  wire logic                      frame_done,
	output logic      [crs_pkg::PIX_W-1:0] adc_data
);
	logic [7:0] row_q;
	logic [7:0] col_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			row_q <= 8'h00;
			col_q <= 8'h00;
			adc_data <= 16'h0000;
		end else if (frame_done) begin
			row_q <= 8'h00;
		end else if (vert_shift) begin
			row_q <= row_q + 8'h01;
			col_q <= 8'h00;
			adc_data <= ~adc_data;
		end else if (serial_shift) begin
			adc_data <= {row_q - 8'h01, col_q};
			col_q <= col_q + 8'h01;
		end
	end
endmodule : crs_sensor_model

// file: test/crs_sequencer_tb.sv
// Self-checking bench for the readout sequencer
`timescale 1ns/100ps
module crs_sequencer_tb;
	logic                      pclk, presetn, psel, penable, pwrite, ext_sync, pready, pslverr, er;
	logic                      vert_shift, serial_shift, adc_convert, store_dump, image_enable;
	logic                      readout_indicator_n, pix_valid, frame_done;
	logic [7:0]                paddr;
	logic [31:0]               pwdata, prdata, rd;
	logic [crs_pkg::PIX_W-1:0] adc_data, pix_data;
	logic [crs_pkg::PIX_W-1:0] pix_q[$];
	int num_errors, n_compared, cyc, t0, n_ser, n_cnv, n_dump, ro_ie, k, e, cp, cols, rows, c0, c1, r0, r1;
	crs_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_sync(ext_sync), .adc_data(adc_data), .vert_shift(vert_shift), .serial_shift(serial_shift),
		.adc_convert(adc_convert), .store_dump(store_dump), .image_enable(image_enable),
		.readout_indicator_n(readout_indicator_n), .pix_valid(pix_valid), .pix_data(pix_data),
		.frame_done(frame_done));
	crs_sensor_model i_array (.pclk(pclk), .presetn(presetn), .vert_shift(vert_shift),
		.serial_shift(serial_shift), .frame_done(frame_done), .adc_data(adc_data));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	function automatic logic [15:0] exp_pix(input int r, input int c);
		return {r[7:0], c[7:0]};
	endfunction : exp_pix
	function automatic int exp_ro(input int nc, input int nr);
		return nr * crs_pkg::LINE_CYC + nr * nc * crs_pkg::PIX_CYC;
	endfunction : exp_ro
	task automatic close_out;
		if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		n_compared++;
		if (got !== want) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, want);
		end
	endtask : chk
	task automatic chk_near(input int got, input int want);
		chk(32'((got > want - 16 && got < want + 16) ? want : got), 32'(want));
	endtask : chk_near
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (pix_valid === 1'b1) pix_q.push_back(pix_data);
		n_ser += int'(serial_shift === 1'b1);
		n_cnv += int'(adc_convert === 1'b1);
		n_dump += int'(store_dump === 1'b1);
		if (readout_indicator_n === 1'b0 && image_enable === 1'b1) ro_ie = 1;
		if (cyc > 60000) begin
			num_errors++;
			close_out();
		end
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rst;
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
	endtask : rst
	task automatic wait_done;
		do @(posedge pclk); while (frame_done !== 1'b1);
		repeat (1) @(posedge pclk);
	endtask : wait_done
	task automatic frame(input logic [31:0] ctrl);
		apb(1'b1, crs_pkg::ADDR_EXP, 32'(e));
		apb(1'b1, crs_pkg::ADDR_COMP, 32'(cp));
		apb(1'b1, crs_pkg::ADDR_DIM, {5'h00, rows[10:0], 5'h00, cols[10:0]});
		apb(1'b1, crs_pkg::ADDR_ROI_C, {5'h00, c1[10:0], 5'h00, c0[10:0]});
		apb(1'b1, crs_pkg::ADDR_ROI_R, {5'h00, r1[10:0], 5'h00, r0[10:0]});
		n_ser = 0; n_cnv = 0; n_dump = 0; ro_ie = 0;
		pix_q.delete();
		apb(1'b1, crs_pkg::ADDR_CTRL, ctrl);
		t0 = cyc;
		wait_done();
	endtask : frame
	task automatic check_pix;
		chk(32'(pix_q.size()), 32'((c1 - c0 + 1) * (r1 - r0 + 1)));
		if (pix_q.size() == (c1 - c0 + 1) * (r1 - r0 + 1))
			for (int r = r0; r <= r1; r++)
				for (int c = c0; c <= c1; c++) chk(32'(pix_q.pop_front()), 32'(exp_pix(r, c)));
	endtask : check_pix
	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; ext_sync = 1'b0;
		num_errors = 0; n_compared = 0; cyc = 0;
		void'($urandom(32'h9BF3));
		rst();
		apb(1'b0, crs_pkg::ADDR_EXP, 32'h0);
		chk(rd, crs_pkg::EXP_RST);
		apb(1'b0, crs_pkg::ADDR_DIM, 32'h0);
		chk(rd, {5'h00, crs_pkg::DIM_RST, 5'h00, crs_pkg::DIM_RST});
		apb(1'b1, 8'h40, 32'hFFFF_FFFF);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, crs_pkg::ADDR_RDCYC, 32'h1234_5678);
		chk({31'h0, er}, 32'h0);
		for (k = 0; k < 3; k++) begin
			cols = 1 + $urandom % 4; rows = 1 + $urandom % 3; e = 10 + $urandom % 40; cp = $urandom % 20;
			c0 = $urandom % cols; c1 = c0 + $urandom % (cols - c0);
			r0 = $urandom % rows; r1 = r0 + $urandom % (rows - r0);
			rst();
			frame(32'h1);
			chk_near(cyc - t0, e + cp + exp_ro(cols, rows));
			chk(32'(n_ser), 32'(rows * cols));
			chk(32'(n_cnv), 32'((c1 - c0 + 1) * (r1 - r0 + 1)));
			check_pix();
			apb(1'b0, crs_pkg::ADDR_RDCYC, 32'h0);
			chk(rd, 32'(exp_ro(cols, rows)));
		end
		cols = 2; rows = 2; c0 = 0; c1 = 1; r0 = 0; r1 = 1; e = 20; cp = 0;
		rst();
		frame(32'h3);
		chk(32'(n_dump), 32'(crs_pkg::DUMP_CYC));
		chk(32'(ro_ie), 32'h1);
		apb(1'b0, crs_pkg::ADDR_RDCYC, 32'h0);
		chk(rd, 32'(exp_ro(cols, rows)));
		rst();
		frame(32'hD);
		chk(32'(ro_ie), 32'h1);
		ro_ie = 0;
		pix_q.delete();
		wait_done();
		chk(32'(ro_ie), 32'h0);
		check_pix();
		repeat (20) @(posedge pclk);
		chk({31'h0, image_enable}, 32'h0);
		ext_sync <= 1'b1;
		repeat (8) @(posedge pclk);
		ext_sync <= 1'b0;
		chk({31'h0, image_enable}, 32'h1);
		rst();
		frame(32'h1D);
		apb(1'b0, crs_pkg::ADDR_CTRL, 32'h0);
		chk(rd, 32'h0000_001D);
		ro_ie = 0;
		wait_done();
		chk(32'(ro_ie), 32'h0);
		chk({31'h0, image_enable}, 32'h1);
		close_out();
	end
endmodule : crs_sequencer_tb
